// *** src/phy_strap_defs.svh ***
// constants for the strap and mode extension register bank
`ifndef PHY_STRAP_DEFS_SVH
`define PHY_STRAP_DEFS_SVH

// register indices; byte address is four times the index
`define IDX_STRAP_LATCH_STATUS 12'h101
`define IDX_MODE_STRAP_OVERRIDE 12'h102
`define IDX_MODE_STRAP_STATUS 12'h103
`define IDX_POWER_OSCILLATOR_CONTROL 12'h107
// own choice: software power down bit of base register 0, mirrored here
`define IDX_BASE_CONTROL 12'h000

`define BIT_REF_CLK_EN 5
`define BIT_TRISTATE 7
`define BIT_NAND_OVR 4
`define BIT_GMII_OVR 1
`define BIT_NAND_STRAP 4
`define BIT_GMII_STRAP 1
`define BIT_REG_DISABLE 15
`define BIT_LOW_FREQ_OSC 8
`define BIT_SW_POWER_DOWN 11

// last value of the post-reset settle count before straps are taken
`define STRAP_SETTLE_LAST 2'h3

`define RST_OVERRIDE 16'h0000
`define RST_POWER_OSC 16'h0000
`define RST_BASE_CONTROL 16'h0000

`endif

// *** src/phy_strap_pkg.sv ***
// types for the strap and mode extension register bank
package phy_strap_pkg;
  typedef struct packed {
    logic ref_clock_out_strap_enable;
    logic [4:0] mgmt_address_strap;
    logic nand_tree;
    logic gmii_mii;
  } strap_s;

  typedef struct packed {
    logic nand_tree_mode;
    logic gmii_mii_mode;
    logic io_tristate;
    logic regulator_off;
    logic osc_low_freq;
    logic sw_power_down;
  } ctrl_s;
endpackage : phy_strap_pkg

// *** src/phy_strap_mode_ext_regs.sv ***
// strap status, mode override and power saving register bank on apb
`include "phy_strap_defs.svh"

module phy_strap_mode_ext_regs #(
  parameter int REG_WIDTH = 16
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire phy_strap_pkg::strap_s strap_pins,
  output phy_strap_pkg::ctrl_s ctrl
);
  import phy_strap_pkg::*;

  // ==========================================================
  // local types and slots
  typedef logic [REG_WIDTH-1:0] reg_word_t;

  typedef enum {
    SEL_NONE,
    SEL_STRAP_STATUS,
    SEL_OVERRIDE,
    SEL_MODE_STATUS,
    SEL_POWER_OSC,
    SEL_BASE
  } reg_sel_e;

  // writable registers share one flop array, addressed by slot
  localparam int NUM_RW = 3;
  localparam int SLOT_OVERRIDE = 0;
  localparam int SLOT_POWER_OSC = 1;
  localparam int SLOT_BASE = 2;
  localparam int LANES = REG_WIDTH / 8;

  // ==========================================================
  // decode helpers
  function automatic logic aligned(input logic [13:0] a);
    aligned = (a[1:0] == 2'h0);
  endfunction : aligned

  // misaligned byte addresses select nothing and so raise an error
  function automatic reg_sel_e decode(input logic [13:0] a);
    reg_sel_e s;
    s = SEL_NONE;
    if (aligned(a)) begin
      case (a[13:2])
        `IDX_STRAP_LATCH_STATUS: s = SEL_STRAP_STATUS;
        `IDX_MODE_STRAP_OVERRIDE: s = SEL_OVERRIDE;
        `IDX_MODE_STRAP_STATUS: s = SEL_MODE_STATUS;
        `IDX_POWER_OSCILLATOR_CONTROL: s = SEL_POWER_OSC;
        `IDX_BASE_CONTROL: s = SEL_BASE;
        default: s = SEL_NONE;
      endcase
    end
    decode = s;
  endfunction : decode

  function automatic reg_sel_e slot_select(input int slot);
    reg_sel_e s;
    s = SEL_NONE;
    if (slot == SLOT_OVERRIDE) begin
      s = SEL_OVERRIDE;
    end else if (slot == SLOT_POWER_OSC) begin
      s = SEL_POWER_OSC;
    end else if (slot == SLOT_BASE) begin
      s = SEL_BASE;
    end
    slot_select = s;
  endfunction : slot_select

  function automatic reg_word_t slot_reset(input int slot);
    reg_word_t v;
    v = '0;
    if (slot == SLOT_OVERRIDE) begin
      v = REG_WIDTH'(`RST_OVERRIDE);
    end else if (slot == SLOT_POWER_OSC) begin
      v = REG_WIDTH'(`RST_POWER_OSC);
    end else if (slot == SLOT_BASE) begin
      v = REG_WIDTH'(`RST_BASE_CONTROL);
    end
    slot_reset = v;
  endfunction : slot_reset

  // byte lanes follow pstrb; lanes beyond the register width are ignored
  function automatic reg_word_t merge(input reg_word_t old, input logic [31:0] wd,
                                      input logic [3:0] st);
    reg_word_t v;
    v = old;
    for (int b = 0; b < LANES; b++) begin
      if (st[b]) begin
        v[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    merge = v;
  endfunction : merge

  // a mode is active when forced by software or chosen by the straps
  function automatic logic mode_active(input logic forced, input logic strapped);
    mode_active = forced | strapped;
  endfunction : mode_active

  // latched values only, overrides are not folded in
  function automatic reg_word_t strap_status(input strap_s s);
    reg_word_t w;
    w = '0;
    w[`BIT_REF_CLK_EN] = s.ref_clock_out_strap_enable;
    w[4:0] = s.mgmt_address_strap;
    strap_status = w;
  endfunction : strap_status

  function automatic reg_word_t mode_status(input strap_s s);
    reg_word_t w;
    w = '0;
    w[`BIT_NAND_STRAP] = s.nand_tree;
    w[`BIT_GMII_STRAP] = s.gmii_mii;
    mode_status = w;
  endfunction : mode_status

  // ==========================================================
  // apb handshake
  reg_sel_e sel;
  logic setup_phase;
  logic access_phase;
  logic write_take;

  assign sel = decode(paddr);
  assign setup_phase = psel && !penable;
  assign access_phase = psel && penable;
  assign write_take = access_phase && pwrite;
  // every register answers in its first access cycle
  assign pready = 1'b1;
  // unmapped addresses answer with an error and read zero
  assign pslverr = access_phase && (sel == SEL_NONE);

  // ==========================================================
  // strap capture
  strap_s strap_meta;
  strap_s strap_sync;
  strap_s strap_latched;
  logic [1:0] settle;
  logic settle_done;
  logic captured;

  // two flops before anything reads the strap pins
  always_ff @(posedge mclk) begin
    strap_meta <= strap_pins;
  end

  always_ff @(posedge mclk) begin
    strap_sync <= strap_meta;
  end

  assign settle_done = (settle == `STRAP_SETTLE_LAST);

  // lets the synchroniser fill with pin levels seen after reset
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      settle <= 2'h0;
    end else if (!settle_done) begin
      settle <= settle + 2'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      captured <= 1'b0;
    end else if (settle_done) begin
      captured <= 1'b1;
    end
  end

  // taken once; later pin activity never reaches status or modes
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      strap_latched <= '0;
    end else if (settle_done && !captured) begin
      strap_latched <= strap_sync;
    end
  end

  // ==========================================================
  // writable registers
  reg_word_t rw_regs [NUM_RW];
  reg_word_t mode_strap_override;
  reg_word_t power_oscillator_control;
  reg_word_t base_control;

  // one flop row per writable register; read-only words hold no storage
  generate
    for (genvar gi = 0; gi < NUM_RW; gi++) begin : g_rw
      always_ff @(posedge mclk) begin
        if (!nrst) begin
          rw_regs[gi] <= slot_reset(gi);
        end else if (write_take && (sel == slot_select(gi))) begin
          rw_regs[gi] <= merge(rw_regs[gi], pwdata, pstrb);
        end
      end
    end
  endgenerate

  assign mode_strap_override = rw_regs[SLOT_OVERRIDE];
  assign power_oscillator_control = rw_regs[SLOT_POWER_OSC];
  assign base_control = rw_regs[SLOT_BASE];

  // ==========================================================
  // read data
  reg_word_t strap_status_word;
  reg_word_t mode_status_word;
  reg_word_t read_mux;

  assign strap_status_word = strap_status(strap_latched);
  assign mode_status_word = mode_status(strap_latched);

  always_comb begin
    read_mux = '0;
    unique case (sel)
      SEL_STRAP_STATUS: read_mux = strap_status_word;
      SEL_OVERRIDE: read_mux = mode_strap_override;
      SEL_MODE_STATUS: read_mux = mode_status_word;
      SEL_POWER_OSC: read_mux = power_oscillator_control;
      SEL_BASE: read_mux = base_control;
      SEL_NONE: read_mux = '0;
    endcase
  end

  // loaded in the setup cycle so it stands through the access cycle
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      prdata <= 32'h00000000;
    end else if (setup_phase && !pwrite) begin
      prdata <= {{(32 - REG_WIDTH){1'b0}}, read_mux};
    end
  end

  // ==========================================================
  // control outputs
  logic power_down;
  logic next_nand_tree_mode;
  logic next_gmii_mii_mode;
  logic next_io_tristate;
  logic next_osc_low_freq;
  logic nand_tree_mode;
  logic gmii_mii_mode;
  logic io_tristate;
  logic regulator_off;
  logic osc_low_freq;
  logic sw_power_down;

  assign power_down = base_control[`BIT_SW_POWER_DOWN];

  always_comb begin
    next_nand_tree_mode = mode_active(mode_strap_override[`BIT_NAND_OVR],
                                      strap_latched.nand_tree);
    next_gmii_mii_mode = mode_active(mode_strap_override[`BIT_GMII_OVR],
                                     strap_latched.gmii_mii);
    // pins stay driven unless power down is also in force
    next_io_tristate = power_down && mode_strap_override[`BIT_TRISTATE];
    // gated by power down so a stray setting cannot slow a live link
    next_osc_low_freq = power_down && power_oscillator_control[`BIT_LOW_FREQ_OSC];
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sw_power_down <= 1'b0;
    end else begin
      sw_power_down <= power_down;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      nand_tree_mode <= 1'b0;
    end else begin
      nand_tree_mode <= next_nand_tree_mode;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      gmii_mii_mode <= 1'b0;
    end else begin
      gmii_mii_mode <= next_gmii_mii_mode;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      io_tristate <= 1'b0;
    end else begin
      io_tristate <= next_io_tristate;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      regulator_off <= 1'b0;
    end else begin
      regulator_off <= power_oscillator_control[`BIT_REG_DISABLE];
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      osc_low_freq <= 1'b0;
    end else begin
      osc_low_freq <= next_osc_low_freq;
    end
  end

  // ==========================================================
  // output carrier
  assign ctrl.nand_tree_mode = nand_tree_mode;
  assign ctrl.gmii_mii_mode = gmii_mii_mode;
  assign ctrl.io_tristate = io_tristate;
  assign ctrl.regulator_off = regulator_off;
  assign ctrl.osc_low_freq = osc_low_freq;
  assign ctrl.sw_power_down = sw_power_down;
endmodule : phy_strap_mode_ext_regs

// *** test/phy_strap_properties.sv ***
// concurrent checks for the strap and mode register bank
module phy_strap_properties (
  input logic mclk,
  input logic nrst,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [13:0] paddr,
  input logic [31:0] pwdata,
  input logic [3:0] pstrb,
  input logic [31:0] prdata,
  input phy_strap_pkg::strap_s strap_pins,
  input phy_strap_pkg::ctrl_s ctrl
);
  timeunit 1ns / 1ps;
  logic [3:0] up; // status means nothing until straps are captured
  always_ff @(posedge mclk) up <= !nrst ? 4'h0 : up + 4'(up < 4'h8);
  wire rd = psel && penable && !pwrite && up == 4'h8;
  wire [1:0] wr = {2{psel && penable && pwrite}} & pstrb[1:0];
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  a_strap_status: assert property (rd && paddr == 14'h404 |->
    prdata[5:0] == strap_pins[7:2]) else $error("strap");
  a_mode_status: assert property (rd && paddr == 14'h40C |->
    {prdata[4], prdata[1]} == strap_pins[1:0]) else $error("mode");
  a_nand_force: assert property (wr[0] && paddr == 14'h408 && pwdata[4] |->
    ##2 ctrl.nand_tree_mode) else $error("nand");
  a_gmii_force: assert property (wr[0] && paddr == 14'h408 && pwdata[1] |->
    ##2 ctrl.gmii_mii_mode) else $error("gmii");
  a_regulator_off: assert property (wr[1] && paddr == 14'h41C |->
    ##2 ctrl.regulator_off == $past(pwdata[15], 2)) else $error("reg");
  a_power_down: assert property (wr[1] && paddr == 14'h000 |->
    ##2 ctrl.sw_power_down == $past(pwdata[11], 2)) else $error("pd");
  a_tri_gate: assert property (ctrl.io_tristate |-> ctrl.sw_power_down)
    else $error("tri");
  a_osc_gate: assert property (ctrl.osc_low_freq |-> ctrl.sw_power_down)
    else $error("osc");
  c_pd: cover property (ctrl.sw_power_down);
  c_nand: cover property (ctrl.nand_tree_mode);
  c_osc: cover property (ctrl.osc_low_freq);
endmodule : phy_strap_properties

// *** test/tb.sv ***
// self-checking bench for the strap and mode register bank
module tb;
  timeunit 1ns / 1ps;
  logic mclk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [13:0] paddr = 14'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0] pstrb = 4'h3;
  phy_strap_pkg::strap_s strap_pins = 8'hD5;
  phy_strap_pkg::ctrl_s ctrl;
  int errors = 0, check_count = 0, cyc = 0;
  logic last_err = 1'b0;
  phy_strap_mode_ext_regs u_phy_strap_mode_ext_regs (.*);
  always #5 mclk = ~mclk;
  always @(posedge mclk) if (++cyc == 2000) complete_run(1);
  task automatic complete_run(input int t);
    errors += t;
    if (errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) errors++;
    if (got !== exp) $display("ERROR %0t %h %h", $time, got, exp);
  endtask : chk
  // reads compare against d
  task automatic xfer(input logic w, input logic [13:0] a, input logic [31:0] d);
    @(posedge mclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    last_err = pslverr;
    {psel, penable} <= 2'h0;
    if (!w) chk(prdata, d);
  endtask : xfer
  task automatic mode(input logic [5:0] x);
    repeat (2) @(posedge mclk);
    chk({26'h0, ctrl}, {26'h0, x});
  endtask : mode
  initial begin
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    repeat (8) @(posedge mclk);
    mode(6'h10);
    xfer(1'b0, 14'h408, 32'h0);
    xfer(1'b0, 14'h41C, 32'h0);
    xfer(1'b0, 14'h000, 32'h0);
    xfer(1'b0, 14'h404, 32'h35);
    chk({31'h0, last_err}, 32'h0);
    xfer(1'b1, 14'h408, 32'h12);
    mode(6'h30);
    xfer(1'b0, 14'h40C, 32'h02);
    xfer(1'b1, 14'h404, 32'hFFFF);
    xfer(1'b0, 14'h404, 32'h35);
    xfer(1'b1, 14'h408, 32'h92);
    xfer(1'b1, 14'h000, 32'h800);
    xfer(1'b1, 14'h41C, 32'h8100);
    mode(6'h3F);
    pstrb <= 4'h1;
    xfer(1'b1, 14'h41C, 32'h0);
    pstrb <= 4'h3;
    xfer(1'b0, 14'h41C, 32'h8100);
    xfer(1'b0, 14'h200, 32'h0);
    chk({31'h0, last_err}, 32'h1);
    nrst <= 1'b0;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    repeat (8) @(posedge mclk);
    mode(6'h10);
    xfer(1'b0, 14'h408, 32'h0);
    complete_run(0);
  end
endmodule : tb
bind phy_strap_mode_ext_regs phy_strap_properties u_phy_strap_properties (.*);
